// File: hdl/plt_map.svh
`ifndef PLT_MAP_SVH
`define PLT_MAP_SVH

// Register indices; the byte address is four times the index
`define PLT_IDX_INDEX 8'h15
`define PLT_IDX_DATA 8'h17
`define PLT_IDX_CTRL 8'h18

// Palette size
`define PLT_ENTRIES 256

// Data register: component field position
`define PLT_COMP_HI 7
`define PLT_COMP_LO 4

// Control register field positions
`define PLT_CTRL_DEPTH_HI 1
`define PLT_CTRL_DEPTH_LO 0
`define PLT_CTRL_MONO 2
`define PLT_CTRL_SEL_HI 6
`define PLT_CTRL_SEL_LO 4

// Reset values
`define PLT_INDEX_RST 8'h00
`define PLT_DEPTH_RST 2'h3
`define PLT_MONO_RST 1'b0

// Pixels per display byte for each depth
`define PLT_PPB_1BPP 4'h8
`define PLT_PPB_2BPP 4'h4
`define PLT_PPB_4BPP 4'h2
`define PLT_PPB_8BPP 4'h1

`endif

// File: hdl/plt_palette.sv
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "plt_map.svh"

// Operation
// - Index register picks one of 256 entries
// - Index steps by one after blue access
// - Each data access moves one 4-bit component
// - Index write sends selector back to red
// - Each data access steps red, green, blue
// - 1 bpp: bit picks entry 0 or 1
// - 2 bpp: code picks entries 0 to 3
// - 4 bpp: nibble picks entries 0 to 15
// - 8 bpp: byte indexes all 256 entries
// - Entries hold independent red, green, blue
// - 1 bpp uses only first two entries
// - Leftmost pixel sits in top bits
// - Mono uses green only; no mono 8 bpp
module plt_palette import plt_pkg::*; (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic pix_valid,
  input wire logic [7:0] pix_byte,
  output logic pix_ready,
  output logic col_valid,
  output plt_rgb_s col_rgb,
  input wire logic col_ready
);

  // Palette storage, no reset: software loads it
  plt_rgb_s pal_q [`PLT_ENTRIES];

  logic [7:0] index_q; // Palette index field
  plt_sel_e sel_q; // Component selector
  plt_depth_e depth_q; // Colour depth
  logic mono_q; // Gray-shade panel
  logic ack_q; // High in the cycle a request completes
  logic [31:0] rdata_q; // Registered read data
  logic req; // A bus request is present
  logic bus_go; // Request completes at this edge
  logic wr_go;
  logic lane0; // Low byte lane enabled
  logic idx_wr; // Index register write
  logic data_go; // Data register access, either direction
  logic data_wr; // Data register write
  logic ctrl_wr; // Control register write
  logic ctrl_ok; // Control write is a legal mode
  logic [3:0] comp_wdata; // Incoming component value
  logic [3:0] comp_rdata; // Selected component of indexed entry
  logic [7:0] rd_byte; // Low byte of read data
  logic u_valid; // Pixel index from the unpacker
  logic [7:0] u_index;
  logic u_ready;
  logic u_take; // Pixel index enters the colour stage
  plt_rgb_s look; // Entry addressed by the pixel
  logic col_valid_q;
  plt_rgb_s col_q;

  // Bus handshake: one wait cycle per request
  assign req = avs_read || avs_write;
  assign avs_waitrequest = req && !ack_q;
  assign bus_go = req && ack_q;
  assign wr_go = bus_go && avs_write;
  assign lane0 = avs_byteenable[0];
  assign idx_wr = wr_go && lane0 && (avs_address == `PLT_IDX_INDEX);
  // Reads with a cleared lane still step the selector
  assign data_go = bus_go && (avs_address == `PLT_IDX_DATA) && (avs_read || lane0);
  assign data_wr = data_go && avs_write;
  assign ctrl_wr = wr_go && lane0 && (avs_address == `PLT_IDX_CTRL);
  assign comp_wdata = avs_writedata[`PLT_COMP_HI:`PLT_COMP_LO];
  assign avs_readdata = rdata_q;

  // Mono and 8 bpp together is not offered
  assign ctrl_ok = !(avs_writedata[`PLT_CTRL_MONO] &&
                     (avs_writedata[`PLT_CTRL_DEPTH_HI:`PLT_CTRL_DEPTH_LO] == PLT_D8));

  // Wait-state generator
  always_ff @(posedge clk) begin
    if (srst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && !ack_q;
    end
  end

  // Component of the indexed entry under the selector
  always_comb begin
    unique case (sel_q)
      PLT_SEL_RED: comp_rdata = pal_q[index_q].red;
      PLT_SEL_GREEN: comp_rdata = pal_q[index_q].green;
      PLT_SEL_BLUE: comp_rdata = pal_q[index_q].blue;
      default: comp_rdata = 4'h0; // Unreachable with one-hot state
    endcase
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    unique case (avs_address)
      `PLT_IDX_INDEX: rd_byte = index_q;
      `PLT_IDX_DATA: rd_byte = {comp_rdata, 4'h0};
      `PLT_IDX_CTRL: rd_byte = {1'b0, sel_q, 1'b0, mono_q, depth_q};
      default: rd_byte = 8'h00;
    endcase
  end

  // Read data sampled in the wait cycle, before state moves
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read && !ack_q) begin
      rdata_q <= {24'h00_0000, rd_byte};
    end
  end

  // Index register: loaded by software, stepped after blue
  always_ff @(posedge clk) begin
    if (srst) begin
      index_q <= `PLT_INDEX_RST;
    end else if (idx_wr) begin
      index_q <= avs_writedata[7:0];
    end else if (data_go && sel_q == PLT_SEL_BLUE) begin
      index_q <= index_q + 8'h01; // Wraps from last entry to first
    end
  end

  // Component selector walk
  always_ff @(posedge clk) begin
    if (srst) begin
      sel_q <= PLT_SEL_RED;
    end else if (idx_wr) begin
      sel_q <= PLT_SEL_RED;
    end else if (data_go) begin
      unique case (sel_q)
        PLT_SEL_RED: sel_q <= PLT_SEL_GREEN;
        PLT_SEL_GREEN: sel_q <= PLT_SEL_BLUE;
        PLT_SEL_BLUE: sel_q <= PLT_SEL_RED;
        default: sel_q <= PLT_SEL_RED; // Recover from an illegal code
      endcase
    end
  end

  // Palette write, one component per access
  always_ff @(posedge clk) begin
    if (data_wr) begin
      unique case (sel_q)
        PLT_SEL_RED: pal_q[index_q].red <= comp_wdata;
        PLT_SEL_GREEN: pal_q[index_q].green <= comp_wdata;
        PLT_SEL_BLUE: pal_q[index_q].blue <= comp_wdata;
        default: pal_q[index_q].red <= pal_q[index_q].red;
      endcase
    end
  end

  // Mode control; an illegal mode write is dropped whole
  always_ff @(posedge clk) begin
    if (srst) begin
      depth_q <= plt_depth_e'(`PLT_DEPTH_RST);
      mono_q <= `PLT_MONO_RST;
    end else if (ctrl_wr && ctrl_ok) begin
      depth_q <= plt_depth_e'(avs_writedata[`PLT_CTRL_DEPTH_HI:`PLT_CTRL_DEPTH_LO]);
      mono_q <= avs_writedata[`PLT_CTRL_MONO];
    end
  end

  // Byte to pixel-index splitter
  plt_pixel_unpack u_unpack (
    .clk(clk),
    .srst(srst),
    .depth(depth_q),
    .in_valid(pix_valid),
    .in_byte(pix_byte),
    .in_ready(pix_ready),
    .out_valid(u_valid),
    .out_index(u_index),
    .out_ready(u_ready)
  );

  // Colour stage accepts when empty or being drained
  assign u_ready = !col_valid_q || col_ready;
  assign u_take = u_valid && u_ready;
  assign look = pal_q[u_index];

  // Colour stage valid flag
  always_ff @(posedge clk) begin
    if (srst) begin
      col_valid_q <= 1'b0;
    end else if (u_ready) begin
      col_valid_q <= u_valid;
    end
  end

  // Colour lookup; gray panels copy green to all three
  always_ff @(posedge clk) begin
    if (srst) begin
      col_q <= '0;
    end else if (u_take) begin
      if (mono_q) begin
        col_q <= '{red: look.green, green: look.green, blue: look.green};
      end else begin
        col_q <= look;
      end
    end
  end

  assign col_valid = col_valid_q;
  assign col_rgb = col_q;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  index_load_a: assert property (
    idx_wr |=> (index_q == $past(avs_writedata[7:0])) && (sel_q == PLT_SEL_RED)
  ) else $error("Index write did not load index and reset selector");

  // Accesses are never back to back, so each step is checked alone
  sel_walk_a: assert property (
    (data_go && sel_q == PLT_SEL_RED) |=> (sel_q == PLT_SEL_GREEN) && $stable(index_q)
  ) else $error("Selector did not step from red to green");

  sel_green_a: assert property (
    (data_go && sel_q == PLT_SEL_GREEN) |=> (sel_q == PLT_SEL_BLUE) && $stable(index_q)
  ) else $error("Selector did not step from green to blue");

  // A write with the low lane off must leave index, selector and depth alone
  lane_drop_a: assert property (
    (wr_go && !lane0) |=> $stable(index_q) && $stable(sel_q) && $stable(depth_q)
  ) else $error("Write with low lane disabled changed state");

  index_step_a: assert property (
    (data_go && !idx_wr && sel_q == PLT_SEL_BLUE)
      |=> (index_q == $past(index_q) + 8'h01) && (sel_q == PLT_SEL_RED)
  ) else $error("Index did not step after the blue access");

  index_hold_a: assert property (
    (!idx_wr && !(data_go && sel_q == PLT_SEL_BLUE)) |=> $stable(index_q)
  ) else $error("Index moved without cause");

  data_read_a: assert property (
    (avs_read && !ack_q && avs_address == `PLT_IDX_DATA)
      |=> !avs_waitrequest && avs_readdata == {24'h00_0000, $past(comp_rdata), 4'h0}
  ) else $error("Data read returned wrong component");

  comp_write_a: assert property (
    (data_wr && sel_q == PLT_SEL_GREEN)
      |=> pal_q[$past(index_q)].green == $past(comp_wdata)
  ) else $error("Green component not stored");

  one_wait_a: assert property (
    (req && !ack_q) |-> avs_waitrequest ##1 (!req || !avs_waitrequest)
  ) else $error("Request not answered after one wait cycle");

  depth1_range_a: assert property (
    (u_valid && depth_q == PLT_D1) |-> (u_index[7:1] == 7'h00)
  ) else $error("1 bpp index outside entries 0 and 1");

  depth2_range_a: assert property (
    (u_valid && depth_q == PLT_D2) |-> (u_index[7:2] == 6'h00)
  ) else $error("2 bpp index outside entries 0 to 3");

  depth4_range_a: assert property (
    (u_valid && depth_q == PLT_D4) |-> (u_index[7:4] == 4'h0)
  ) else $error("4 bpp index outside entries 0 to 15");

  lookup_a: assert property (
    (u_take && !mono_q && !data_wr) |=> col_valid && col_rgb == $past(look)
  ) else $error("Colour does not match palette entry");

  mono_gray_a: assert property (
    (col_valid && mono_q && $stable(mono_q))
      |-> (col_rgb.red == col_rgb.green) && (col_rgb.blue == col_rgb.green)
  ) else $error("Gray output not taken from green");

  no_mono8_a: assert property (
    !(mono_q && depth_q == PLT_D8)
  ) else $error("Gray mode at 8 bpp");

  stall_hold_a: assert property (
    (col_valid && !col_ready) |=> col_valid && $stable(col_rgb)
  ) else $error("Colour changed while stalled");

  rgb_triplet_c: cover property (
    (data_wr && sel_q == PLT_SEL_BLUE && index_q == 8'hff) ##1 (index_q == 8'h00)
  );

  eight_bpp_c: cover property (
    col_valid && col_ready && depth_q == PLT_D8 && !mono_q
  );

  mono_out_c: cover property (
    col_valid && col_ready && mono_q && depth_q == PLT_D4
  );

  read_back_c: cover property (
    bus_go && avs_read && avs_address == `PLT_IDX_DATA && sel_q == PLT_SEL_BLUE
  );

endmodule // plt_palette

// File: hdl/plt_pixel_unpack.sv
`timescale 1ns/1ps
`include "plt_map.svh"

// Splits display bytes into palette indices, leftmost pixel first
module plt_pixel_unpack import plt_pkg::*; (
  input wire logic clk,
  input wire logic srst,
  input wire plt_depth_e depth,
  input wire logic in_valid,
  input wire logic [7:0] in_byte,
  output logic in_ready,
  output logic out_valid,
  output logic [7:0] out_index,
  input wire logic out_ready
);

  logic [7:0] sh_q; // Byte being split, next pixel in the top bits
  logic [3:0] cnt_q; // Pixels left in the byte
  logic [3:0] ppb; // Pixels per byte at this depth
  logic in_take;
  logic out_take;

  assign out_valid = (cnt_q != 4'h0);
  assign out_take = out_valid && out_ready;
  // Accept a new byte once the last pixel of the current one leaves
  assign in_ready = (cnt_q == 4'h0) || ((cnt_q == 4'h1) && out_ready);
  assign in_take = in_valid && in_ready;

  // Pixel count and index width per depth
  always_comb begin
    unique case (depth)
      PLT_D1: begin
        ppb = `PLT_PPB_1BPP;
        out_index = {7'h00, sh_q[7]};
      end
      PLT_D2: begin
        ppb = `PLT_PPB_2BPP;
        out_index = {6'h00, sh_q[7:6]};
      end
      PLT_D4: begin
        ppb = `PLT_PPB_4BPP;
        out_index = {4'h0, sh_q[7:4]};
      end
      PLT_D8: begin
        ppb = `PLT_PPB_8BPP;
        out_index = sh_q;
      end
    endcase
  end

  // Shift register; a depth change mid-byte garbles that byte only
  always_ff @(posedge clk) begin
    if (srst) begin
      sh_q <= 8'h00;
      cnt_q <= 4'h0;
    end else if (in_take) begin
      sh_q <= in_byte;
      cnt_q <= ppb;
    end else if (out_take) begin
      // Most significant bits go first, then lower ones
      unique case (depth)
        PLT_D1: sh_q <= {sh_q[6:0], 1'b0};
        PLT_D2: sh_q <= {sh_q[5:0], 2'h0};
        PLT_D4: sh_q <= {sh_q[3:0], 4'h0};
        PLT_D8: sh_q <= 8'h00;
      endcase
      cnt_q <= cnt_q - 4'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  leftmost_first_a: assert property (
    (in_take && depth == PLT_D4) |=> (out_index == {4'h0, $past(in_byte[7:4])})
  ) else $error("First pixel is not the top nibble");

  second_pixel_a: assert property (
    (in_take && depth == PLT_D4) ##1 (out_take && $stable(depth))
      |=> (out_index == {4'h0, $past(in_byte[3:0], 2)})
  ) else $error("Second pixel is not the low nibble");

endmodule // plt_pixel_unpack

// File: hdl/plt_pkg.sv
package plt_pkg;

  // Colour depth codes held in the control register
  typedef enum logic [1:0] {
    PLT_D1 = 2'h0,
    PLT_D2 = 2'h1,
    PLT_D4 = 2'h2,
    PLT_D8 = 2'h3
  } plt_depth_e;

  // Component selector, one-hot
  typedef enum logic [2:0] {
    PLT_SEL_RED = 3'h1,
    PLT_SEL_GREEN = 3'h2,
    PLT_SEL_BLUE = 3'h4
  } plt_sel_e;

  // One palette entry, 4 bits per component
  typedef struct packed {
    logic [3:0] red;
    logic [3:0] green;
    logic [3:0] blue;
  } plt_rgb_s;

endpackage

// File: test/plt_host.sv
`timescale 1ns/1ps

// Host-side bus master for the palette registers
module plt_host (
  input wire logic clk,
  output logic [7:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  // Bus idle from time zero
  initial begin
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
  end

  // One access; held until waitrequest is sampled low, bound guards a hang
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                      input logic [3:0] be, output logic [31:0] q, output logic ok);
    int n;
    ok = 1'b0;
    q = 32'h0;
    avs_address <= a;
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    for (n = 0; n < 64 && !ok; n++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) begin
        ok = 1'b1;
        q = avs_readdata;
      end
    end
    // Released lines stop showing the old value
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= ~avs_writedata;
    avs_address <= ~avs_address;
    @(posedge clk);
  endtask
endmodule // plt_host

// File: test/plt_palette_tb.sv
`timescale 1ns/1ps
`include "plt_map.svh"

// Self-checking bench: register access and pixel lookup
module plt_palette_tb import plt_pkg::*;;
  logic clk;
  logic srst;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic pix_valid;
  logic [7:0] pix_byte;
  logic pix_ready;
  logic col_valid;
  plt_rgb_s col_rgb;
  logic col_ready;
  logic stall; // Toggles col_ready to back-pressure the pipe
  plt_rgb_s got[$]; // Colours seen downstream
  int err_total;
  int n_checks;

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  plt_palette u_dut (.clk(clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pix_valid(pix_valid), .pix_byte(pix_byte),
    .pix_ready(pix_ready), .col_valid(col_valid), .col_rgb(col_rgb),
    .col_ready(col_ready));

  plt_host u_host (.clk(clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  // Collect accepted colours; stall mode alternates ready
  always @(posedge clk) begin
    if (col_valid === 1'b1 && col_ready === 1'b1) got.push_back(col_rgb);
    col_ready <= stall ? ~col_ready : 1'b1;
  end

  // Single comparison point
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Register access; a hung bus ends the run
  task automatic io(input logic wr, input logic [7:0] a, input logic [7:0] d,
                    input logic [3:0] be, output logic [31:0] q);
    logic ok;
    u_host.xfer(wr, a, d, be, q, ok);
    if (!ok) begin
      err_total++;
      close_out();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    io(1'b1, a, d, 4'h1, q);
  endtask

  // Read and compare in one go
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    io(1'b0, a, 8'h00, 4'hf, q);
    chk(what, q, exp);
  endtask

  // Colour stored at each entry; components differ so swaps show
  function automatic plt_rgb_s ent(input logic [7:0] i);
    return '{i[3:0], ~i[3:0], i[3:0] ^ 4'h5};
  endfunction

  // Load entries; junk in low bits must be dropped
  task automatic fill(input logic [7:0] s, input int cnt);
    plt_rgb_s c;
    wr(`PLT_IDX_INDEX, s);
    for (int k = 0; k < cnt; k++) begin
      c = ent(s + 8'(k));
      wr(`PLT_IDX_DATA, {c.red, 4'h9});
      wr(`PLT_IDX_DATA, {c.green, 4'h9});
      wr(`PLT_IDX_DATA, {c.blue, 4'h9});
    end
  endtask

  // Reset values and an unmapped place
  task automatic t_reset();
    rdc("index", `PLT_IDX_INDEX, 32'h00);
    rdc("ctrl", `PLT_IDX_CTRL, 32'h13);
    rdc("unmapped", 8'h16, 32'h00);
  endtask

  // Index stepping, wrap, selector order, refused writes
  task automatic t_regs();
    logic [11:0] v;
    logic [31:0] q;
    v = ent(8'hff);
    fill(8'hfe, 2);
    rdc("wrap", `PLT_IDX_INDEX, 32'h00);
    wr(`PLT_IDX_INDEX, 8'hff);
    rdc("red", `PLT_IDX_DATA, {24'h0, v[11:8], 4'h0});
    rdc("sel", `PLT_IDX_CTRL, 32'h23);
    wr(`PLT_IDX_INDEX, 8'hff);
    rdc("sel", `PLT_IDX_CTRL, 32'h13);
    // Reads step the selector and index just as writes do
    for (int k = 0; k < 3; k++)
      rdc("comp", `PLT_IDX_DATA, {24'h0, v[11-4*k -: 4], 4'h0});
    rdc("step", `PLT_IDX_INDEX, 32'h00);
    io(1'b1, `PLT_IDX_INDEX, 8'h42, 4'h0, q);
    rdc("no lane", `PLT_IDX_INDEX, 32'h00);
    wr(`PLT_IDX_CTRL, 8'h07);
    rdc("mono8", `PLT_IDX_CTRL, 32'h13);
  endtask

  // One display byte at depth d, mono m; compare every colour out
  task automatic px(input logic [1:0] d, input logic m, input logic [7:0] b);
    int w;
    int n;
    logic [7:0] e;
    plt_rgb_s c;
    wr(`PLT_IDX_CTRL, {5'h0, m, d});
    w = 1 << d;
    got.delete();
    pix_valid <= 1'b1;
    pix_byte <= b;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pix_ready !== 1'b1 && n < 64);
    pix_valid <= 1'b0;
    // Byte never taken: count it and stop
    if (pix_ready !== 1'b1) begin
      err_total++;
      close_out();
    end
    for (n = 0; n < 60 && got.size() < 8 / w; n++) @(posedge clk);
    repeat (3) @(posedge clk);
    chk("count", 32'(got.size()), 32'(8 / w));
    if (got.size() != 8 / w) begin
      err_total++;
      close_out();
    end
    for (int k = 0; k < 8 / w; k++) begin
      e = 8'((b >> (8 - w * (k + 1))) & ((1 << w) - 1));
      c = ent(e);
      if (m) c = '{c.green, c.green, c.green};
      chk("colour", 32'(got[k]), 32'(c));
    end
  endtask

  // Every depth, with stall and mono
  task automatic t_pix();
    fill(8'h00, 16);
    stall <= 1'b1;
    px(2'h0, 1'b0, 8'ha5);
    stall <= 1'b0;
    px(2'h1, 1'b0, 8'h1b);
    px(2'h2, 1'b0, 8'h3c);
    px(2'h3, 1'b0, 8'hff);
    px(2'h3, 1'b0, 8'h00);
    px(2'h2, 1'b1, 8'h5a);
    px(2'h0, 1'b1, 8'h96);
  endtask

  // Main sequence
  initial begin
    srst = 1'b1;
    pix_valid = 1'b0;
    pix_byte = 8'h00;
    stall = 1'b0;
    err_total = 0;
    n_checks = 0;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_regs();
    t_pix();
    close_out();
  end
endmodule // plt_palette_tb
